// File: pio_consts.vh
// Constants for the parallel port bank: register indices, reset values.
// Included by every design file of the block; definitions only.
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH

// Register index on the word-addressed bus (byte address = 4 * index)
`define PIO_IDX_W 12
`define PIO_IDX_P1_LATCH 12'h001
`define PIO_IDX_P2_LATCH 12'h002
`define PIO_IDX_P3_LATCH 12'h003
`define PIO_IDX_P3_SEG 12'h004
`define PIO_IDX_P5_LATCH 12'h005
`define PIO_IDX_P6_LATCH 12'h006
`define PIO_IDX_P7_LATCH 12'h007
`define PIO_IDX_P1_PIN 12'h008
`define PIO_IDX_P2_PIN 12'h009
`define PIO_IDX_P3_PIN 12'h00a
`define PIO_IDX_P5_PIN 12'h00b
`define PIO_IDX_P6_DIR 12'h00c
`define PIO_IDX_P7_PIN 12'h00d
`define PIO_IDX_P1_SEG 12'h029
`define PIO_IDX_P5_SEG 12'h02a
`define PIO_IDX_P7_SEG 12'h02b
`define PIO_IDX_FSEL 12'hfc0

// Reset values
`define PIO_RST_LATCH8 8'hff
`define PIO_RST_LATCH7 7'h7f
`define PIO_RST_LATCH3 3'h7
`define PIO_RST_ZERO8 8'h00
`define PIO_RST_ZERO7 7'h00

// Total number of port pins, synchronised as one vector
`define PIO_NPINS 42

// Function select bit positions
`define PIO_FS_DIV 0
`define PIO_FS_TMR3 1
`define PIO_FS_TMR4 2
`define PIO_FS_TMR6 3
`define PIO_FS_IRQ1 4
`define PIO_FS_IRQ2 5
`define PIO_FS_IRQ3 6

`endif

// File: pio_sync.v
// Two-stage synchroniser for asynchronous pin levels.
// Assumes one clock; the first stage feeds only the second.
`timescale 1ns/1ps
`include "pio_consts.vh"
module pio_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire clk_sys_i,
   input wire reset_i,
   // Data
   input wire [W-1:0] async_i,
   output reg [W-1:0] sync_o
);
   reg [W-1:0] stage1;

   // Zero at reset, so pins read low until two edges after release
   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         stage1 <= {W{1'b0}};
         sync_o <= {W{1'b0}};
      end else begin
         stage1 <= async_i;
         sync_o <= stage1;
      end
   end
endmodule

// File: pio_fsel.v
// Routing of interrupt, timer and divider functions to port pins.
// Assumes synchronised pin levels and a stable select register.
`timescale 1ns/1ps
`include "pio_consts.vh"
module pio_fsel (
   // Select register
   input wire [6:0] fsel_i,
   // Synchronised pins
   input wire [7:0] p1_sync_i,
   input wire [6:0] p3_sync_i,
   input wire [7:0] p7_sync_i,
   // Function outputs from peripherals
   input wire timer3_out_i,
   input wire timer4_out_i,
   input wire timer6_out_i,
   input wire divider_out_i,
   // Gating masks for the pin drive, one where no function sits
   output wire [6:0] p3_fn_o,
   output wire [7:0] p7_fn_o,
   // Function inputs towards peripherals
   output wire irq1_pin_o,
   output wire irq2_pin_o,
   output wire irq3_pin_o,
   output wire timer3_in_o,
   output wire timer4_in_o,
   output wire timer6_in_o
);
   wire [3:0] fn_out;
   wire [3:0] fn_sel;

   assign fn_out = {timer6_out_i, timer4_out_i, timer3_out_i, divider_out_i};
   assign fn_sel = fsel_i[3:0];

   // Zero selects the port-3 pin, one the port-7 pin
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_fn
         assign p3_fn_o[g] = fn_sel[g] | fn_out[g];
         assign p7_fn_o[g + 1] = ~fn_sel[g] | fn_out[g];
      end
   endgenerate
   assign p3_fn_o[6:4] = 3'h7;
   assign p7_fn_o[0] = 1'b1;
   assign p7_fn_o[7:5] = 3'h7;

   assign irq1_pin_o = fsel_i[`PIO_FS_IRQ1] ? p3_sync_i[4] :
                       p1_sync_i[2];
   assign irq2_pin_o = fsel_i[`PIO_FS_IRQ2] ? p3_sync_i[5] :
                       p1_sync_i[3];
   assign irq3_pin_o = fsel_i[`PIO_FS_IRQ3] ? p3_sync_i[6] :
                       p1_sync_i[4];
   assign timer3_in_o = fsel_i[`PIO_FS_TMR3] ? p7_sync_i[2] : p3_sync_i[1];
   assign timer4_in_o = fsel_i[`PIO_FS_TMR4] ? p7_sync_i[3] : p3_sync_i[2];
   assign timer6_in_o = fsel_i[`PIO_FS_TMR6] ? p7_sync_i[4] : p3_sync_i[3];
endmodule

// File: pio_top.v
// Six parallel ports with latches, pin readback, LCD hand-over, analog
// sharing on port 6 and a function pin select register.
// Assumes an Avalon-MM master on clk_sys_i and asynchronous pin levels.
`timescale 1ns/1ps
`include "pio_consts.vh"
module pio_top (
   // Clock and reset
   input wire clk_sys_i,
   input wire reset_i,
   // Avalon-MM slave, word addressed
   input wire [`PIO_IDX_W-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   // Port 1 pins
   input wire [7:0] port1_pin_i,
   output wire [7:0] port1_pin_o,
   output wire [7:0] port1_pin_oe_o,
   // Port 2 pins
   input wire [2:0] port2_pin_i,
   output wire [2:0] port2_pin_o,
   output wire [2:0] port2_pin_oe_o,
   // Port 3 pins
   input wire [6:0] port3_pin_i,
   output wire [6:0] port3_pin_o,
   output wire [6:0] port3_pin_oe_o,
   // Port 5 pins
   input wire [7:0] port5_pin_i,
   output wire [7:0] port5_pin_o,
   output wire [7:0] port5_pin_oe_o,
   // Port 6 pins
   input wire [7:0] port6_pin_i,
   output wire [7:0] port6_pin_o,
   output wire [7:0] port6_pin_oe_o,
   // Port 7 pins
   input wire [7:0] port7_pin_i,
   output wire [7:0] port7_pin_o,
   output wire [7:0] port7_pin_oe_o,
   // LCD segment and common drive levels
   input wire [7:0] port1_lcd_i,
   input wire [6:0] port3_lcd_i,
   input wire [7:0] port5_lcd_i,
   input wire [7:0] port7_lcd_i,
   // Slow oscillator
   input wire dual_clock_mode_i,
   input wire slow_osc_out_i,
   output wire slow_osc_in_o,
   // Analog sharing on port 6
   output wire [7:0] port6_analog_en_o,
   output wire [7:0] port6_in_o,
   // Interrupt, timer and divider functions
   output wire port2_int_pin_o,
   output wire irq1_pin_o,
   output wire irq2_pin_o,
   output wire irq3_pin_o,
   output wire timer3_in_o,
   output wire timer4_in_o,
   output wire timer6_in_o,
   input wire timer3_out_i,
   input wire timer4_out_i,
   input wire timer6_out_i,
   input wire divider_out_i
);
   // Software-visible state
   // Widths follow the pin counts; narrow ports read zero above
   reg [7:0] port1_out_latch;
   reg [2:0] port2_out_latch;
   reg [6:0] port3_out_latch;
   reg [7:0] port5_out_latch;
   reg [7:0] port6_out_latch;
   reg [7:0] port7_out_latch;
   reg [7:0] port1_segment_select;
   reg [6:0] port3_segment_select;
   reg [7:0] port5_segment_select;
   reg [7:0] port7_common_select;
   reg [7:0] port6_direction_control;
   reg [6:0] function_pin_select;

   // Bus cycle state: zero is the first state, one the second
   reg bus_phase;
   reg [7:0] next_rdata;
   wire bus_req;
   wire wr_take;
   wire [7:0] wd;

   // Synchronised pins
   // One vector, so every pin sees the same two-flop delay
   wire [`PIO_NPINS-1:0] pins_sync;
   wire [7:0] p1_sync;
   wire [2:0] p2_sync;
   wire [6:0] p3_sync;
   wire [7:0] p5_sync;
   wire [7:0] p6_sync;
   wire [7:0] p7_sync;

   // Pin readback views
   wire [7:0] port1_pin_readback;
   wire [2:0] port2_pin_readback;
   wire [6:0] port3_pin_readback;
   wire [7:0] port5_pin_readback;
   wire [7:0] port7_pin_readback;
   wire [7:0] port6_read;
   wire [7:0] p6_analog;

   // Function gating of pin drive
   wire [6:0] p3_fn;
   wire [7:0] p7_fn;
   wire [6:0] p3_drive;
   wire [7:0] p7_drive;
   wire osc_pins;

   pio_sync #(
      .W(`PIO_NPINS)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .async_i({port7_pin_i, port6_pin_i, port5_pin_i, port3_pin_i,
                port2_pin_i, port1_pin_i}),
      .sync_o(pins_sync)
   );

   assign p1_sync = pins_sync[7:0];
   assign p2_sync = pins_sync[10:8];
   assign p3_sync = pins_sync[17:11];
   assign p5_sync = pins_sync[25:18];
   assign p6_sync = pins_sync[33:26];
   assign p7_sync = pins_sync[41:34];

   pio_fsel u_fsel (
      .fsel_i(function_pin_select),
      .p1_sync_i(p1_sync),
      .p3_sync_i(p3_sync),
      .p7_sync_i(p7_sync),
      .timer3_out_i(timer3_out_i),
      .timer4_out_i(timer4_out_i),
      .timer6_out_i(timer6_out_i),
      .divider_out_i(divider_out_i),
      .p3_fn_o(p3_fn),
      .p7_fn_o(p7_fn),
      .irq1_pin_o(irq1_pin_o),
      .irq2_pin_o(irq2_pin_o),
      .irq3_pin_o(irq3_pin_o),
      .timer3_in_o(timer3_in_o),
      .timer4_in_o(timer4_in_o),
      .timer6_in_o(timer6_in_o)
   );

   // Two-state bus cycle: the first state samples, the second commits
   assign bus_req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = bus_req & ~bus_phase;
   assign wr_take = avs_write_i & bus_phase;
   assign wd = avs_writedata_i[7:0];

   // A held request drops back to the wait state: back to back works
   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         bus_phase <= 1'b0;
      end else begin
         bus_phase <= bus_req & ~bus_phase;
      end
   end

   // Readback masks: LCD-owned pins and analog pins read as zero
   // Pins lag the wires by two edges through the synchroniser
   assign port1_pin_readback = p1_sync & ~port1_segment_select;
   assign port2_pin_readback = p2_sync;
   assign port3_pin_readback = p3_sync & ~port3_segment_select;
   assign port5_pin_readback = p5_sync & ~port5_segment_select;
   assign port7_pin_readback = p7_sync & ~port7_common_select;
   assign p6_analog = ~port6_direction_control & ~port6_out_latch;
   // Port 6 has no readback index; its latch index gives this view
   // Output bits return the latch, inputs the pin, analog bits zero
   assign port6_read = (port6_direction_control & port6_out_latch) |
                       (~port6_direction_control & p6_sync &
                        ~p6_analog);

   // Decoded from the held address, captured in the first state
   always @* begin
      next_rdata = `PIO_RST_ZERO8;
      case (avs_address_i)
         `PIO_IDX_P1_LATCH: next_rdata = port1_out_latch;
         // Upper bits are undefined; zero is returned
         `PIO_IDX_P2_LATCH: next_rdata = {5'h00, port2_out_latch};
         `PIO_IDX_P3_LATCH: next_rdata = {1'b0, port3_out_latch};
         `PIO_IDX_P3_SEG: next_rdata = {1'b0, port3_segment_select};
         `PIO_IDX_P5_LATCH: next_rdata = port5_out_latch;
         `PIO_IDX_P6_LATCH: next_rdata = port6_read;
         `PIO_IDX_P7_LATCH: next_rdata = port7_out_latch;
         `PIO_IDX_P1_PIN: next_rdata = port1_pin_readback;
         `PIO_IDX_P2_PIN: next_rdata = {5'h00, port2_pin_readback};
         `PIO_IDX_P3_PIN: next_rdata = {1'b0, port3_pin_readback};
         `PIO_IDX_P5_PIN: next_rdata = port5_pin_readback;
         `PIO_IDX_P6_DIR: next_rdata = port6_direction_control;
         `PIO_IDX_P7_PIN: next_rdata = port7_pin_readback;
         `PIO_IDX_P1_SEG: next_rdata = port1_segment_select;
         `PIO_IDX_P5_SEG: next_rdata = port5_segment_select;
         `PIO_IDX_P7_SEG: next_rdata = port7_common_select;
         `PIO_IDX_FSEL: next_rdata = {1'b0, function_pin_select};
         default: next_rdata = `PIO_RST_ZERO8;
      endcase
   end

   // Pins are captured in the first state, held until the next read
   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i & ~bus_phase) begin
         avs_readdata_o <= {24'h00_0000, next_rdata};
      end
   end

   // Register writes land at the edge that ends the second state
   // Only byte lane 0 carries data; upper write bits are ignored
   always @(posedge clk_sys_i) begin
      if (reset_i) begin
         port1_out_latch <= `PIO_RST_LATCH8;
         port2_out_latch <= `PIO_RST_LATCH3;
         port3_out_latch <= `PIO_RST_LATCH7;
         port5_out_latch <= `PIO_RST_LATCH8;
         port7_out_latch <= `PIO_RST_LATCH8;
         port1_segment_select <= `PIO_RST_ZERO8;
         port3_segment_select <= `PIO_RST_ZERO7;
         port5_segment_select <= `PIO_RST_ZERO8;
         port7_common_select <= `PIO_RST_ZERO8;
         port6_out_latch <= `PIO_RST_ZERO8;
         port6_direction_control <= `PIO_RST_ZERO8;
         function_pin_select <= `PIO_RST_ZERO7;
      end else if (wr_take) begin
         case (avs_address_i)
            `PIO_IDX_P1_LATCH: port1_out_latch <= wd;
            `PIO_IDX_P2_LATCH: port2_out_latch <= wd[2:0];
            `PIO_IDX_P3_LATCH: port3_out_latch <= wd[6:0];
            `PIO_IDX_P3_SEG: port3_segment_select <= wd[6:0];
            `PIO_IDX_P5_LATCH: port5_out_latch <= wd;
            `PIO_IDX_P6_LATCH: port6_out_latch <= wd;
            `PIO_IDX_P7_LATCH: port7_out_latch <= wd;
            `PIO_IDX_P6_DIR: port6_direction_control <= wd;
            `PIO_IDX_P1_SEG: port1_segment_select <= wd;
            `PIO_IDX_P5_SEG: port5_segment_select <= wd;
            `PIO_IDX_P7_SEG: port7_common_select <= wd;
            `PIO_IDX_FSEL: function_pin_select <= wd[6:0];
            // Readback and unmapped indices ignore writes
            default: port1_out_latch <= port1_out_latch;
         endcase
      end
   end

   // Open-drain style: a latch one releases the pin so it can be read.
   // Segment-owned pins are driven by the LCD level instead.
   assign port1_pin_o = port1_segment_select & port1_lcd_i;
   assign port1_pin_oe_o = port1_segment_select | ~port1_out_latch;
   assign port5_pin_o = port5_segment_select & port5_lcd_i;
   assign port5_pin_oe_o = port5_segment_select | ~port5_out_latch;

   // Timer and divider outputs pull the pin low through the latch path
   // A latch zero would mask the function, hence software keeps it one
   assign p3_drive = port3_out_latch & p3_fn;
   assign p7_drive = port7_out_latch & p7_fn;
   assign port3_pin_o = port3_segment_select & port3_lcd_i;
   assign port3_pin_oe_o = port3_segment_select | ~p3_drive;
   assign port7_pin_o = port7_common_select & port7_lcd_i;
   assign port7_pin_oe_o = port7_common_select | ~p7_drive;

   // Dual-clock mode gives the upper two pins to the slow oscillator
   // Bit 2 drives the resonator, bit 1 is released to listen to it
   assign osc_pins = dual_clock_mode_i;
   assign port2_pin_o = {osc_pins & slow_osc_out_i, 2'h0};
   assign port2_pin_oe_o = {osc_pins | ~port2_out_latch[2],
                            ~osc_pins & ~port2_out_latch[1],
                            ~port2_out_latch[0]};
   assign slow_osc_in_o = osc_pins & p2_sync[1];
   // Interrupt source watches the pin itself, so driven pulses count
   assign port2_int_pin_o = p2_sync[0];

   // Port 6: direction one drives the latch level; zero is input/analog
   assign port6_pin_o = port6_out_latch;
   assign port6_pin_oe_o = port6_direction_control;
   // Writes during a conversion disturb accuracy; not blocked here
   assign port6_analog_en_o = p6_analog;
   // Analog bits read zero here too, so function inputs stay quiet
   assign port6_in_o = p6_sync & ~p6_analog;
endmodule

// File: pio_top_monitor.sv
// Checker for the port bank: bus wait timing, port 6 and oscillator pins.
// Assumes it is bound to pio_top and everything runs on clk_sys_i.
`timescale 1ns/1ps
`include "pio_consts.vh"
module pio_top_monitor (
   // Clock and reset
   input wire clk_sys_i,
   input wire reset_i,
   // Bus
   input wire [11:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   // Pins
   input wire [7:0] port1_pin_oe_o,
   input wire [2:0] port2_pin_o,
   input wire [2:0] port2_pin_oe_o,
   input wire [7:0] port6_pin_o,
   input wire [7:0] port6_pin_oe_o,
   input wire [7:0] port6_analog_en_o,
   input wire [7:0] port6_in_o,
   input wire dual_clock_mode_i,
   input wire slow_osc_out_i
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);
   reg [7:0] wd_q;
   wire req = avs_read_i | avs_write_i;
   wire wr_done = avs_write_i & ~avs_waitrequest_o;
   always @(posedge clk_sys_i) begin
      wd_q <= avs_writedata_i[7:0];
   end
   sequence s_wait;
      req && avs_waitrequest_o;
   endsequence
   sequence s_answer;
      !avs_waitrequest_o;
   endsequence
   a_one_wait: assert property (s_wait |=> s_answer)
      else $error("answer not in second cycle");
   a_wait_first: assert property ($rose(req) |-> s_wait)
      else $error("no wait in first cycle");
   a_p6_latch_out: assert property (wr_done &&
      avs_address_i == `PIO_IDX_P6_LATCH |=> port6_pin_o == wd_q)
      else $error("port 6 level not written");
   a_p6_dir_out: assert property (wr_done &&
      avs_address_i == `PIO_IDX_P6_DIR |=> port6_pin_oe_o == wd_q)
      else $error("port 6 direction not written");
   a_analog_map: assert property (port6_analog_en_o ==
      (~port6_pin_oe_o & ~port6_pin_o))
      else $error("analog select wrong");
   a_analog_zero: assert property (
      (port6_in_o & port6_analog_en_o) == 8'h00)
      else $error("analog bit reads nonzero");
   a_reset_vals: assert property ($fell(reset_i) |->
      port1_pin_oe_o == 8'h00 && port6_analog_en_o == 8'hff)
      else $error("pin state after reset wrong");
   a_read_upper: assert property (avs_read_i &&
      !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
      else $error("upper read bits nonzero");
   a_slow_osc: assert property (dual_clock_mode_i |->
      port2_pin_oe_o[2:1] == 2'b10 && port2_pin_o[2] == slow_osc_out_i)
      else $error("oscillator pins wrong");
endmodule
bind pio_top pio_top_monitor u_mon (.clk_sys_i, .reset_i, .avs_address_i,
   .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
   .avs_waitrequest_o, .port1_pin_oe_o, .port2_pin_o, .port2_pin_oe_o,
   .port6_pin_o, .port6_pin_oe_o, .port6_analog_en_o, .port6_in_o,
   .dual_clock_mode_i, .slow_osc_out_i);

// File: pio_pins_model.sv
// External circuits on the 42 port pins.
// Assumes the bench gives the outside drive level of every pin.
`timescale 1ns/1ps
module pio_pins_model (
   // From the ports
   input wire [41:0] drv_i,
   input wire [41:0] oe_i,
   // Outside drive
   input wire [41:0] ext_i,
   // Wire level back to the ports
   output wire [41:0] lvl_o
);
   // Driven pins win, released pins follow the outside circuit
   assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// File: tb.sv
// Self-checking bench for pio_top: register bus, pins, routing.
// Assumes pio_pins_model closes the pins; reads are scored from a queue.
`timescale 1ns/1ps
`include "pio_consts.vh"
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin \
   fails++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
   logic clk_sys_i = 0, reset_i = 1, avs_read_i = 0, avs_write_i = 0;
   logic [11:0] avs_address_i = 0;
   logic [31:0] avs_writedata_i = 0;
   logic [7:0] port1_lcd_i = 0, port5_lcd_i = 0, port7_lcd_i = 0, e6 = 0;
   logic [6:0] port3_lcd_i = 0;
   logic [2:0] e2 = 0;
   logic dual_clock_mode_i = 0, slow_osc_out_i = 0, divider_out_i = 1;
   logic timer3_out_i = 1, timer4_out_i = 1, timer6_out_i = 1;
   logic [7:0] xe [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] lv [4], sv [4], v, f, e;
   logic [11:0] a;
   logic [11:0] li [4] = '{12'h001, 12'h003, 12'h005, 12'h007};
   logic [11:0] si [4] = '{12'h029, 12'h004, 12'h02a, 12'h02b};
   logic [11:0] pi [4] = '{12'h008, 12'h00a, 12'h00b, 12'h00d};
   logic [7:0] mk [4] = '{8'hff, 8'h7f, 8'hff, 8'hff};
   logic [11:0] ra [13] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h005,
      12'h006, 12'h007, 12'h029, 12'h02a, 12'h02b, 12'h00c, 12'hfc0, 12'h0ff};
   logic [7:0] rv [13] = '{8'hff, 8'h07, 8'h7f, 8'h00, 8'hff, 8'h00, 8'hff,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] exp_q [$];
   logic [11:0] adr_q [$];
   integer seed = 96161, fails = 0, n_checks = 0, i;
   wire [31:0] avs_readdata_o;
   wire avs_waitrequest_o, slow_osc_in_o, port2_int_pin_o;
   wire irq1_pin_o, irq2_pin_o, irq3_pin_o;
   wire timer3_in_o, timer4_in_o, timer6_in_o;
   wire [7:0] port1_pin_i, port1_pin_o, port1_pin_oe_o;
   wire [2:0] port2_pin_i, port2_pin_o, port2_pin_oe_o;
   wire [6:0] port3_pin_i, port3_pin_o, port3_pin_oe_o;
   wire [7:0] port5_pin_i, port5_pin_o, port5_pin_oe_o;
   wire [7:0] port6_pin_i, port6_pin_o, port6_pin_oe_o;
   wire [7:0] port7_pin_i, port7_pin_o, port7_pin_oe_o;
   wire [7:0] port6_analog_en_o, port6_in_o;
   wire [41:0] lvl;
   always #12.5 clk_sys_i = ~clk_sys_i;
   pio_top uut (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .port1_pin_i(port1_pin_i), .port1_pin_o(port1_pin_o),
      .port1_pin_oe_o(port1_pin_oe_o),
      .port2_pin_i(port2_pin_i), .port2_pin_o(port2_pin_o),
      .port2_pin_oe_o(port2_pin_oe_o),
      .port3_pin_i(port3_pin_i), .port3_pin_o(port3_pin_o),
      .port3_pin_oe_o(port3_pin_oe_o),
      .port5_pin_i(port5_pin_i), .port5_pin_o(port5_pin_o),
      .port5_pin_oe_o(port5_pin_oe_o),
      .port6_pin_i(port6_pin_i), .port6_pin_o(port6_pin_o),
      .port6_pin_oe_o(port6_pin_oe_o),
      .port7_pin_i(port7_pin_i), .port7_pin_o(port7_pin_o),
      .port7_pin_oe_o(port7_pin_oe_o),
      .port1_lcd_i(port1_lcd_i), .port3_lcd_i(port3_lcd_i),
      .port5_lcd_i(port5_lcd_i), .port7_lcd_i(port7_lcd_i),
      .dual_clock_mode_i(dual_clock_mode_i),
      .slow_osc_out_i(slow_osc_out_i), .slow_osc_in_o(slow_osc_in_o),
      .port6_analog_en_o(port6_analog_en_o), .port6_in_o(port6_in_o),
      .port2_int_pin_o(port2_int_pin_o),
      .irq1_pin_o(irq1_pin_o), .irq2_pin_o(irq2_pin_o),
      .irq3_pin_o(irq3_pin_o),
      .timer3_in_o(timer3_in_o), .timer4_in_o(timer4_in_o),
      .timer6_in_o(timer6_in_o),
      .timer3_out_i(timer3_out_i), .timer4_out_i(timer4_out_i),
      .timer6_out_i(timer6_out_i), .divider_out_i(divider_out_i)
   );
   pio_pins_model u_pins (
      .drv_i({port7_pin_o, port6_pin_o, port5_pin_o, port3_pin_o,
         port2_pin_o, port1_pin_o}),
      .oe_i({port7_pin_oe_o, port6_pin_oe_o, port5_pin_oe_o, port3_pin_oe_o,
         port2_pin_oe_o, port1_pin_oe_o}),
      .ext_i({xe[3], e6, xe[2], xe[1][6:0], e2, xe[0]}),
      .lvl_o(lvl)
   );
   assign {port7_pin_i, port6_pin_i, port5_pin_i, port3_pin_i, port2_pin_i,
      port1_pin_i} = lvl;
   task summarize;
      begin
         $display("checks %0d fails %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // One transfer; a read takes d as the expected byte
   task bus(input bit w, input [11:0] ad, input [7:0] d);
      integer k;
      logic [31:0] r;
      begin
         @(posedge clk_sys_i);
         r = $random(seed);
         avs_address_i <= ad;
         avs_read_i <= !w;
         avs_write_i <= w;
         avs_writedata_i <= {r[31:8], d};
         if (!w) begin
            exp_q.push_back(d);
            adr_q.push_back(ad);
         end
         k = 0;
         do begin
            @(posedge clk_sys_i);
            k++;
         end while (avs_waitrequest_o !== 1'b0 && k < 16);
         if (k == 16) begin
            fails++;
            summarize();
         end else begin
            avs_read_i <= 0;
            avs_write_i <= 0;
         end
      end
   endtask
   always @(posedge clk_sys_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0) begin
         e = exp_q.pop_front();
         a = adr_q.pop_front();
         `CHK($sformatf("reg %h", a), {24'h0,e}, avs_readdata_o)
      end
   end
   initial begin
      #1000000;
      fails++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clk_sys_i);
      reset_i <= 0;
      port1_lcd_i <= $random(seed);
      port5_lcd_i <= $random(seed);
      port3_lcd_i <= $random(seed);
      port7_lcd_i <= $random(seed);
      for (i = 0; i < 13; i++)
         bus(0, ra[i], rv[i]);
      for (i = 0; i < 4; i++) begin
         lv[i] = $random(seed);
         sv[i] = $random(seed);
         bus(1, li[i], lv[i]);
         bus(0, li[i], lv[i] & mk[i]);
         bus(1, si[i], sv[i]);
         bus(0, si[i], sv[i] & mk[i]);
         xe[i] <= $random(seed);
      end
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `CHK("p1 oe", sv[0] | ~lv[0], port1_pin_oe_o)
      `CHK("p1 out", sv[0] & port1_lcd_i, port1_pin_o)
      `CHK("p5 oe", sv[2] | ~lv[2], port5_pin_oe_o)
      `CHK("p5 out", sv[2] & port5_lcd_i, port5_pin_o)
      `CHK("p3 out", sv[1][6:0] & port3_lcd_i, port3_pin_o)
      `CHK("p7 out", sv[3] & port7_lcd_i, port7_pin_o)
      for (i = 0; i < 4; i++)
         bus(0, pi[i], xe[i] & lv[i] & ~sv[i] & mk[i]);
      e2 <= 3'b111;
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `CHK("p2 int hi", 1'b1, port2_int_pin_o)
      bus(1, `PIO_IDX_P2_LATCH, 8'h06);
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `CHK("p2 int", 1'b0, port2_int_pin_o)
      bus(0, `PIO_IDX_P2_PIN, 8'h06);
      dual_clock_mode_i <= 1;
      slow_osc_out_i <= 1;
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `CHK("osc in", 1'b1, slow_osc_in_o)
      `CHK("osc out", 1'b1, port2_pin_o[2])
      dual_clock_mode_i <= 0;
      bus(1, `PIO_IDX_P2_LATCH, 8'h07);
      // No conversion is started, so port writes stay free
      bus(1, `PIO_IDX_P6_LATCH, 8'hff);
      e6 <= $random(seed);
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `CHK("p6 in", e6, port6_in_o)
      bus(0, `PIO_IDX_P6_LATCH, e6);
      bus(1, `PIO_IDX_P6_LATCH, 8'h00);
      bus(0, `PIO_IDX_P6_LATCH, 8'h00);
      @(negedge clk_sys_i);
      `CHK("p6 analog", 8'hff, port6_analog_en_o)
      v = $random(seed);
      bus(1, `PIO_IDX_P6_DIR, 8'hff);
      bus(1, `PIO_IDX_P6_LATCH, v);
      bus(0, `PIO_IDX_P6_LATCH, v);
      bus(0, `PIO_IDX_P6_DIR, 8'hff);
      for (i = 0; i < 4; i++) begin
         bus(1, li[i], 8'hff);
         bus(1, si[i], 8'h00);
      end
      xe[0] <= 8'hff;
      xe[1] <= 8'h0f;
      xe[3] <= 8'h00;
      for (i = 0; i < 2; i++) begin
         f = i ? 8'h7f : 8'h00;
         bus(1, `PIO_IDX_FSEL, f);
         bus(0, `PIO_IDX_FSEL, f);
         repeat (4) @(posedge clk_sys_i);
         @(negedge clk_sys_i);
         `CHK("routes", {6{!i[0]}}, {irq3_pin_o, irq2_pin_o, irq1_pin_o,
            timer6_in_o, timer4_in_o, timer3_in_o})
         @(posedge clk_sys_i);
         {timer6_out_i, timer4_out_i, timer3_out_i, divider_out_i} <= 4'h0;
         repeat (2) @(posedge clk_sys_i);
         @(negedge clk_sys_i);
         `CHK("fn pins", {{4{i[0]}}, {4{!i[0]}}}, {port7_pin_oe_o[4:1],
            port3_pin_oe_o[3:0]})
         @(posedge clk_sys_i);
         {timer6_out_i, timer4_out_i, timer3_out_i, divider_out_i} <= 4'hf;
      end
      summarize();
   end
endmodule
